/* logic/sdi_cmd_core.sv */
/*
  Command decoder of a four-bank 16-bit synchronous DRAM: address
  multiplexing, bank select, mode load, byte masks and clock-gate power states.
  Assumes the controller keeps start-up order and all command spacing.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - row 13 bits at activate, column 9
// - bank pins pick opened or accessed bank
// - chip select high ignores commands, ops continue
// - strobe levels decode the command
// - inputs sampled on rising edge only
// - read mask floats byte two cycles later
// - write mask blocks byte same cycle
// - clock gate low enters self refresh on a refresh, else power down only with all banks closed
// - mode set is all strobes low
// - mode loads from address same cycle
module sdi_cmd_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // command pins
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnableN,
  input wire logic [sdi_pkg::ROW_W-1:0] addrPins,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic clockGate,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  // array side
  output logic [sdi_pkg::ROW_W-1:0] rowAddr,
  output logic [sdi_pkg::COL_W-1:0] colAddr,
  output logic [sdi_pkg::BANK_W-1:0] bankSel,
  output logic rowOpenStb,
  output logic colReadStb,
  output logic colWriteStb,
  output logic [1:0] writeByteEn,
  output logic [1:0] readByteOe,
  output logic [sdi_pkg::BANKS-1:0] bankOpen,
  output logic [sdi_pkg::ROW_W-1:0] modeWord,
  output logic modeValid,
  output logic powerDown,
  output logic selfRefresh
);
  sdi_cmd_if cmdBus();

  sdi_pin_sampler u_smp (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .chipSelN(chipSelN),
    .rowStrobeN(rowStrobeN),
    .colStrobeN(colStrobeN),
    .writeEnableN(writeEnableN),
    .addrPins(addrPins),
    .bank_select_lo(bank_select_lo),
    .bank_select_hi(bank_select_hi),
    .clockGate(clockGate),
    .cmd(cmdBus.src)
  );

  typedef struct packed {
    logic [sdi_pkg::ROW_W-1:0] rowAddr;
    logic [sdi_pkg::COL_W-1:0] colAddr;
    logic [sdi_pkg::BANK_W-1:0] bankSel;
    logic rowOpenStb;
    logic colReadStb;
    logic colWriteStb;
    logic [1:0] writeByteEn;
    logic [1:0] maskD1;
    logic [1:0] readByteOe;
    logic [sdi_pkg::BANKS-1:0] bankOpen;
    logic [sdi_pkg::ROW_W-1:0] modeWord;
    logic modeValid;
    sdi_pkg::sdi_pwr_e pwr;
  } sdi_core_s;

  sdi_core_s st_r;
  sdi_core_s st_nxt;
  logic [1:0] maskIn;
  logic cmdLive;

  assign maskIn = {upper_byte_mask, lower_byte_mask};
  // a command only acts while the clock gate was high at its edge
  assign cmdLive = cmdBus.valid && cmdBus.clkGate && st_r.pwr == sdi_pkg::SDI_PWR_ACTIVE;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rowOpenStb = 1'b0;
    st_nxt.colReadStb = 1'b0;
    st_nxt.colWriteStb = 1'b0;
    st_nxt.writeByteEn = 2'h0;
    // mask pipeline runs regardless of chip select
    st_nxt.maskD1 = maskIn;
    st_nxt.readByteOe = ~st_r.maskD1;
    if (cmdLive) begin
      case (cmdBus.code)
        sdi_pkg::CMD_ACTIVATE: begin
          st_nxt.rowAddr = cmdBus.addr;
          st_nxt.bankSel = cmdBus.bank;
          st_nxt.rowOpenStb = 1'b1;
          st_nxt.bankOpen[cmdBus.bank] = 1'b1;
        end
        sdi_pkg::CMD_READ: begin
          st_nxt.colAddr = cmdBus.addr[sdi_pkg::COL_W-1:0];
          st_nxt.bankSel = cmdBus.bank;
          st_nxt.colReadStb = 1'b1;
        end
        sdi_pkg::CMD_WRITE: begin
          st_nxt.colAddr = cmdBus.addr[sdi_pkg::COL_W-1:0];
          st_nxt.bankSel = cmdBus.bank;
          st_nxt.colWriteStb = 1'b1;
        end
        sdi_pkg::CMD_PRECHARGE: begin
          // address bit 10 selects all banks
          if (cmdBus.addr[sdi_pkg::ALL_BANKS_BIT]) begin
            st_nxt.bankOpen = '0;
          end else begin
            st_nxt.bankOpen[cmdBus.bank] = 1'b0;
          end
        end
        sdi_pkg::CMD_MODE_SET: begin
          st_nxt.modeWord = cmdBus.addr;
          st_nxt.modeValid = 1'b1;
        end
        default: begin
          // no-operation, refresh and burst stop leave the decoder state alone
        end
      endcase
    end
    // the mask registered with the write command applies, so there is no latency;
    // the live pin already belongs to the next cycle
    if (st_nxt.colWriteStb) begin
      st_nxt.writeByteEn = ~st_r.maskD1;
    end
    // low-power entry and exit follow the clock gate
    case (st_r.pwr)
      sdi_pkg::SDI_PWR_ACTIVE: begin
        if (!cmdBus.clkGate) begin
          if (cmdBus.valid && cmdBus.code == sdi_pkg::CMD_REFRESH) begin
            st_nxt.pwr = sdi_pkg::SDI_PWR_SELF_REF;
          end else if (st_r.bankOpen == '0) begin
            st_nxt.pwr = sdi_pkg::SDI_PWR_DOWN;
          end
        end
      end
      sdi_pkg::SDI_PWR_DOWN, sdi_pkg::SDI_PWR_SELF_REF: begin
        if (cmdBus.clkGate) begin
          st_nxt.pwr = sdi_pkg::SDI_PWR_ACTIVE;
        end
      end
      default: st_nxt.pwr = sdi_pkg::SDI_PWR_ACTIVE;
    endcase
    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.bankOpen = sdi_pkg::ROW_OPEN_RST;
      st_nxt.pwr = sdi_pkg::SDI_PWR_ACTIVE;
      st_nxt.readByteOe = 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  assign rowAddr = st_r.rowAddr;
  assign colAddr = st_r.colAddr;
  assign bankSel = st_r.bankSel;
  assign rowOpenStb = st_r.rowOpenStb;
  assign colReadStb = st_r.colReadStb;
  assign colWriteStb = st_r.colWriteStb;
  assign writeByteEn = st_r.writeByteEn;
  assign readByteOe = st_r.readByteOe;
  assign bankOpen = st_r.bankOpen;
  assign modeWord = st_r.modeWord;
  assign modeValid = st_r.modeValid;
  // one-hot state, so each flag is a state bit straight from the register
  assign powerDown = st_r.pwr[1];
  assign selfRefresh = st_r.pwr[2];

  activate_row_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rowOpenStb |-> rowAddr == $past(addrPins, 2)) else $error("row address mismatch");
  read_bank_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    colReadStb |-> bankSel == $past({bank_select_hi, bank_select_lo}, 2))
    else $error("read bank mismatch");
  deselect_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past(chipSelN, 2) |-> !rowOpenStb && !colReadStb && !colWriteStb)
    else $error("command taken while deselected");
  decode_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    colReadStb |-> $past({rowStrobeN, colStrobeN, writeEnableN}, 2) == sdi_pkg::CMD_READ)
    else $error("read strobe from wrong code");
  read_mask_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lower_byte_mask ##2 1'b1 |-> !readByteOe[0]) else $error("read mask latency wrong");
  write_mask_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    colWriteStb |-> writeByteEn == ~$past({upper_byte_mask, lower_byte_mask}, 2))
    else $error("write mask not applied");
  powerdown_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    powerDown |-> bankOpen == '0) else $error("power down with open bank");
  mode_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(modeValid) |-> modeWord == $past(addrPins, 2)) else $error("mode word not loaded");
  mode_set_code_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(modeValid) |-> $past({chipSelN, rowStrobeN, colStrobeN, writeEnableN}, 2) == 4'h0)
    else $error("mode set from wrong code");
  nop_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $past({rowStrobeN, colStrobeN, writeEnableN}, 2) == sdi_pkg::CMD_NO_OPERATION
    |-> !rowOpenStb && !colReadStb && !colWriteStb) else $error("no-operation acted");
endmodule

/* logic/sdi_cmd_if.sv */
/*
  Decoded-command carrier between the pin front end and the decoder.
  Assumes one clock; fields are valid in the cycle they are presented.
*/
`timescale 1ns/1ps
interface sdi_cmd_if;
  logic valid;
  logic [2:0] code;
  logic [sdi_pkg::ROW_W-1:0] addr;
  logic [sdi_pkg::BANK_W-1:0] bank;
  logic clkGate;
  modport src (output valid, output code, output addr, output bank, output clkGate);
  modport dst (input valid, input code, input addr, input bank, input clkGate);
endinterface

/* logic/sdi_pin_sampler.sv */
/*
  Pin front end: registers every device input except the byte masks on the rising edge and
  presents a decoded command when chip select is active.
  Assumes pins are synchronous to ref_clk, so one sampling stage is used.
*/
`timescale 1ns/1ps
module sdi_pin_sampler (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pins
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnableN,
  input wire logic [sdi_pkg::ROW_W-1:0] addrPins,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic clockGate,
  // decoded command
  sdi_cmd_if.src cmd
);
  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic [sdi_pkg::ROW_W-1:0] addr;
    logic [sdi_pkg::BANK_W-1:0] bank;
    logic clkGate;
  } sdi_smp_s;
  sdi_smp_s st_r;
  sdi_smp_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = ~chipSelN;
    st_nxt.code = {rowStrobeN, colStrobeN, writeEnableN};
    st_nxt.addr = addrPins;
    st_nxt.bank = {bank_select_hi, bank_select_lo};
    st_nxt.clkGate = clockGate;
    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.code = sdi_pkg::CMD_NO_OPERATION;
      st_nxt.clkGate = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  assign cmd.valid = st_r.valid;
  assign cmd.code = st_r.code;
  assign cmd.addr = st_r.addr;
  assign cmd.bank = st_r.bank;
  assign cmd.clkGate = st_r.clkGate;

  deselect_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chipSelN |=> !cmd.valid) else $error("deselected cycle produced a command");
endmodule

/* logic/sdi_pkg.sv */
/*
  Package for the synchronous DRAM command front end: pin widths, command
  encodings and the read-mask latency.
  Assumes nothing of its surroundings; every other file uses it by scope.
*/
package sdi_pkg;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int BANK_W = 2;
  localparam int BANKS = 4;
  localparam int MASK_LAT = 2;
  // command code is {rowStrobeN, colStrobeN, writeEnableN}
  localparam logic [2:0] CMD_MODE_SET = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_BURST_STOP = 3'h6;
  localparam logic [2:0] CMD_NO_OPERATION = 3'h7;
  localparam logic [3:0] ROW_OPEN_RST = 4'h0;
  // address bit that widens a precharge to every bank
  localparam int ALL_BANKS_BIT = 10;
  typedef enum logic [2:0] {
    SDI_PWR_ACTIVE = 3'b001,
    SDI_PWR_DOWN = 3'b010,
    SDI_PWR_SELF_REF = 3'b100
  } sdi_pwr_e;
endpackage

/* tb/sdi_ctrl_model.sv */
/*
  Memory controller model that drives the command pins of the DRAM front end.
  Assumes the bench calls its tasks and that ref_clk runs free.
*/
`timescale 1ns/1ps
module sdi_ctrl_model (
  // clock
  input wire logic ref_clk,
  // command pins
  output logic chipSelN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeEnableN,
  output logic [12:0] addrPins,
  output logic bank_select_lo,
  output logic bank_select_hi,
  output logic clockGate,
  output logic lower_byte_mask,
  output logic upper_byte_mask
);
  // 200 us at 25 MHz
  localparam int PAUSE_CYC = 5000;
  localparam int MRS_GAP = 2;
  // spacing between activations of two banks; any value above the device minimum serves
  localparam int BANK_GAP = 3;
  initial begin
    chipSelN = 1'b0;
    {rowStrobeN, colStrobeN, writeEnableN} = sdi_pkg::CMD_NO_OPERATION;
    {upper_byte_mask, lower_byte_mask, clockGate} = 3'h7;
    addrPins = 13'h0000;
    {bank_select_hi, bank_select_lo} = 2'h0;
  end
  // one command cycle, then no-operation; the gate level is left as given
  task automatic send(input logic csN, input logic [2:0] code, input logic [1:0] bank,
                      input logic [12:0] addr, input logic [1:0] mask, input logic gate);
    @(posedge ref_clk);
    #1;
    chipSelN = csN;
    {rowStrobeN, colStrobeN, writeEnableN} = code;
    {bank_select_hi, bank_select_lo} = bank;
    addrPins = addr;
    {upper_byte_mask, lower_byte_mask} = mask;
    clockGate = gate;
    @(posedge ref_clk);
    #1;
    chipSelN = 1'b0;
    {rowStrobeN, colStrobeN, writeEnableN} = sdi_pkg::CMD_NO_OPERATION;
    // stale address is not held: a lazy decoder must not see the old value
    addrPins = ~addr;
    {bank_select_hi, bank_select_lo} = ~bank;
  endtask
  // mode value is never assumed before it is written
  task automatic init_seq(input logic [12:0] mode);
    repeat (PAUSE_CYC) @(posedge ref_clk);
    send(1'b0, sdi_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 2'h3, 1'b1);
    // the run is far shorter than one refresh interval, so these cover it
    repeat (8) send(1'b0, sdi_pkg::CMD_REFRESH, 2'h0, 13'h0000, 2'h3, 1'b1);
    send(1'b0, sdi_pkg::CMD_MODE_SET, 2'h0, mode, 2'h3, 1'b1);
    repeat (MRS_GAP) @(posedge ref_clk);
  endtask
  task automatic bank_gap();
    repeat (BANK_GAP) @(posedge ref_clk);
  endtask
endmodule

/* tb/tb_sdram_init_and_activate.sv */
/*
  Self-checking bench for sdi_cmd_core, driven through the controller model.
  Assumes outputs appear one edge after the edge that samples the pins.
*/
`timescale 1ns/1ps
module tb_sdram_init_and_activate;
  logic ref_clk, sys_rst, chipSelN, rowStrobeN, colStrobeN, writeEnableN;
  logic bank_select_lo, bank_select_hi, clockGate, lower_byte_mask, upper_byte_mask;
  logic rowOpenStb, colReadStb, colWriteStb, modeValid, powerDown, selfRefresh;
  logic [12:0] addrPins, rowAddr, modeWord;
  logic [8:0] colAddr;
  logic [1:0] bankSel, writeByteEn, readByteOe;
  logic [3:0] bankOpen;
  int error_cnt = 0;
  int comparisons = 0;
  sdi_ctrl_model ctl_u (.ref_clk(ref_clk), .chipSelN(chipSelN), .rowStrobeN(rowStrobeN),
    .colStrobeN(colStrobeN), .writeEnableN(writeEnableN), .addrPins(addrPins),
    .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi), .clockGate(clockGate),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask));
  sdi_cmd_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelN(chipSelN),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnableN(writeEnableN),
    .addrPins(addrPins), .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi),
    .clockGate(clockGate), .lower_byte_mask(lower_byte_mask),
    .upper_byte_mask(upper_byte_mask), .rowAddr(rowAddr), .colAddr(colAddr),
    .bankSel(bankSel), .rowOpenStb(rowOpenStb), .colReadStb(colReadStb),
    .colWriteStb(colWriteStb), .writeByteEn(writeByteEn), .readByteOe(readByteOe),
    .bankOpen(bankOpen), .modeWord(modeWord), .modeValid(modeValid),
    .powerDown(powerDown), .selfRefresh(selfRefresh));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // send returns just after the sampling edge; strobes stand in the next cycle only
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic t_init();
    chk("modeValid", 13'h0000, modeValid);
    ctl_u.init_seq(13'h0032);
    #1;
    chk("modeWord", 13'h0032, modeWord);
    chk("modeValid", 13'h0001, modeValid);
  endtask
  task automatic t_activate();
    ctl_u.send(1'b0, sdi_pkg::CMD_ACTIVATE, 2'h2, 13'h1abc, 2'h0, 1'b1);
    settle();
    chk("rowOpenStb", 13'h0001, rowOpenStb);
    chk("rowAddr", 13'h1abc, rowAddr);
    chk("bankSel", 13'h0002, bankSel);
    chk("bankOpen", 13'h0004, bankOpen);
    @(posedge ref_clk);
    #1;
    chk("rowOpenStb", 13'h0000, rowOpenStb);
    ctl_u.bank_gap();
    ctl_u.send(1'b0, sdi_pkg::CMD_ACTIVATE, 2'h0, 13'h0e01, 2'h0, 1'b1);
    settle();
    chk("rowAddr", 13'h0e01, rowAddr);
    chk("bankSel", 13'h0000, bankSel);
    chk("bankOpen", 13'h0005, bankOpen);
  endtask
  task automatic t_access();
    ctl_u.send(1'b0, sdi_pkg::CMD_WRITE, 2'h2, 13'h09a5, 2'h1, 1'b1);
    settle();
    chk("colWriteStb", 13'h0001, colWriteStb);
    chk("colAddr", 13'h01a5, colAddr);
    chk("writeByteEn", 13'h0002, writeByteEn);
    ctl_u.send(1'b0, sdi_pkg::CMD_READ, 2'h2, 13'h0033, 2'h2, 1'b1);
    settle();
    chk("colReadStb", 13'h0001, colReadStb);
    chk("colAddr", 13'h0033, colAddr);
    chk("readByteOe", 13'h0001, readByteOe);
  endtask
  task automatic t_ignore();
    ctl_u.send(1'b1, sdi_pkg::CMD_ACTIVATE, 2'h1, 13'h0055, 2'h0, 1'b1);
    settle();
    chk("rowOpenStb", 13'h0000, rowOpenStb);
    chk("bankOpen", 13'h0005, bankOpen);
    chk("rowAddr", 13'h0e01, rowAddr);
    ctl_u.send(1'b0, sdi_pkg::CMD_NO_OPERATION, 2'h3, 13'h1fff, 2'h0, 1'b1);
    settle();
    chk("strobes", 13'h0000, {rowOpenStb, colReadStb, colWriteStb});
    chk("bankSel", 13'h0002, bankSel);
    chk("colAddr", 13'h0033, colAddr);
  endtask
  task automatic t_power();
    ctl_u.send(1'b0, sdi_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 1'b1);
    settle();
    chk("bankOpen", 13'h0000, bankOpen);
    ctl_u.send(1'b0, sdi_pkg::CMD_NO_OPERATION, 2'h0, 13'h0000, 2'h0, 1'b0);
    settle();
    chk("powerDown", 13'h0001, powerDown);
    ctl_u.send(1'b0, sdi_pkg::CMD_ACTIVATE, 2'h1, 13'h0077, 2'h0, 1'b0);
    settle();
    chk("rowOpenStb", 13'h0000, rowOpenStb);
    chk("bankOpen", 13'h0000, bankOpen);
    ctl_u.send(1'b0, sdi_pkg::CMD_NO_OPERATION, 2'h0, 13'h0000, 2'h0, 1'b1);
    settle();
    chk("powerDown", 13'h0000, powerDown);
    ctl_u.send(1'b0, sdi_pkg::CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 1'b0);
    settle();
    chk("selfRefresh", 13'h0001, selfRefresh);
    chk("powerDown", 13'h0000, powerDown);
    ctl_u.send(1'b0, sdi_pkg::CMD_NO_OPERATION, 2'h0, 13'h0000, 2'h0, 1'b1);
    settle();
    chk("selfRefresh", 13'h0000, selfRefresh);
  endtask
  // reopen a closed bank on a new row, then reset in mid-run
  task automatic t_reset();
    ctl_u.send(1'b0, sdi_pkg::CMD_ACTIVATE, 2'h2, 13'h0123, 2'h1, 1'b1);
    settle();
    chk("rowAddr", 13'h0123, rowAddr);
    chk("bankOpen", 13'h0004, bankOpen);
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    chk("bankOpen", 13'h0000, bankOpen);
    chk("modeValid", 13'h0000, modeValid);
    chk("powerDown", 13'h0000, powerDown);
    chk("readByteOe", 13'h0000, readByteOe);
    chk("rowOpenStb", 13'h0000, rowOpenStb);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("readByteOe", 13'h0002, readByteOe);
  endtask
  // init pause dominates; the margin covers every scenario after it
  initial begin
    #(7000 * 40);
    error_cnt++;
    finish_test();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_init();
    t_activate();
    t_access();
    t_ignore();
    t_power();
    t_reset();
    finish_test();
  end
endmodule
